// ==== spce_top.sv ====
// Serial control-enable block: APB registers, receive filter, interrupt gating, pin routing
`timescale 1ns/1ns
module spce_top
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic [spce_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [spce_pkg::DATA_W-1:0]   pwdata,
    output logic      [spce_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire spce_pkg::spce_rx_event_type   rx_event,
    input  wire logic                          tx_data_empty,
    input  wire logic                          tx_all_sent,
    input  wire logic                          tx_serial_out,
    input  wire logic                          gpio_txd_data,
    input  wire logic                          gpio_txd_oe_n,
    input  wire logic                          rxd_pin_in,
    output logic                               rx_active,
    output logic                               tx_active,
    output logic                               rx_serial_data,
    output logic                               rxd_gpio_data,
    output logic                               txd_pin_out,
    output logic                               txd_pin_oe_n,
    output logic                               rx_full_irq,
    output logic                               rx_error_irq,
    output logic                               tx_empty_irq,
    output logic                               tx_end_irq,
    output logic                               irq
);

    spce_pkg::spce_state_type s;
    spce_pkg::spce_state_type next_s;

    logic setup_phase;
    logic wr_access;
    logic rx_take;
    logic rx_accept;
    logic mp_release;
    logic [spce_pkg::ST_W-1:0] req_vec;
    logic [spce_pkg::ST_W-1:0] status_vec;

    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && s.pready && pwrite;
    assign rx_take     = rx_event.valid && s.ctrl.rx_en;
    assign rx_accept   = rx_take && (!s.ctrl.mp_filter_en || rx_event.mp_bit);
    assign mp_release  = rx_take && s.ctrl.mp_filter_en && rx_event.mp_bit;
    assign status_vec  = {s.tx_end_seen, s.tx_empty_seen, s.flags};

    always_comb
    begin
        next_s = s;
        req_vec = '0;

        // Bus answer: one wait-free access phase after each setup cycle
        next_s.pready  = setup_phase;
        next_s.pslverr = setup_phase && !(paddr == spce_pkg::CTRL_OFFSET
                                          || paddr == spce_pkg::STATUS_OFFSET
                                          || paddr == spce_pkg::MASK_OFFSET);
        next_s.prdata  = '0;
        if (setup_phase && !pwrite)
        begin
            case (paddr)
                spce_pkg::CTRL_OFFSET:
                    next_s.prdata = {{(spce_pkg::DATA_W-spce_pkg::CTRL_W){1'b0}}, s.ctrl};
                spce_pkg::STATUS_OFFSET:
                    next_s.prdata = {{(spce_pkg::DATA_W-spce_pkg::ST_W){1'b0}}, status_vec};
                spce_pkg::MASK_OFFSET:
                    next_s.prdata = {{(spce_pkg::DATA_W-spce_pkg::ST_W){1'b0}}, s.mask};
                default:
                    next_s.prdata = '0;
            endcase
        end

        // Software writes
        if (wr_access && paddr == spce_pkg::CTRL_OFFSET)
        begin
            next_s.ctrl = spce_pkg::spce_ctrl_type'(pwdata[spce_pkg::CTRL_W-1:0]);
        end
        if (wr_access && paddr == spce_pkg::MASK_OFFSET)
        begin
            next_s.mask = pwdata[spce_pkg::ST_W-1:0];
        end
        if (wr_access && paddr == spce_pkg::STATUS_OFFSET)
        begin
            next_s.flags = s.flags & ~pwdata[2:0];
        end

        // Hardware clears the filter enable; it overrides a same-cycle write
        if (mp_release)
        begin
            next_s.ctrl.mp_filter_en = 1'b0;
        end

        // Frame flags set only by accepted frames; set wins over a clear
        if (rx_accept)
        begin
            next_s.flags[spce_pkg::ST_RX_FULL] = 1'b1;
            if (rx_event.framing_err)
            begin
                next_s.flags[spce_pkg::ST_FRAMING] = 1'b1;
            end
            if (rx_event.overrun)
            begin
                next_s.flags[spce_pkg::ST_OVERRUN] = 1'b1;
            end
        end

        next_s.tx_empty_seen = tx_data_empty;
        next_s.tx_end_seen   = tx_all_sent;

        // Requests gated by their enables; the receive requests also by the filter
        next_s.rx_full_irq  = next_s.ctrl.rx_ie && !next_s.ctrl.mp_filter_en
                              && next_s.flags[spce_pkg::ST_RX_FULL];
        next_s.rx_error_irq = next_s.ctrl.rx_ie && !next_s.ctrl.mp_filter_en
                              && (next_s.flags[spce_pkg::ST_FRAMING]
                                  || next_s.flags[spce_pkg::ST_OVERRUN]);
        next_s.tx_empty_irq = next_s.ctrl.tx_empty_ie && tx_data_empty;
        next_s.tx_end_irq   = next_s.ctrl.tx_end_ie && tx_all_sent;

        req_vec[spce_pkg::ST_RX_FULL]  = next_s.rx_full_irq;
        req_vec[spce_pkg::ST_FRAMING]  = next_s.rx_error_irq
                                         && next_s.flags[spce_pkg::ST_FRAMING];
        req_vec[spce_pkg::ST_OVERRUN]  = next_s.rx_error_irq
                                         && next_s.flags[spce_pkg::ST_OVERRUN];
        req_vec[spce_pkg::ST_TX_EMPTY] = next_s.tx_empty_irq;
        req_vec[spce_pkg::ST_TX_END]   = next_s.tx_end_irq;
        next_s.irq = |(req_vec & next_s.mask);

        // Pin routing
        next_s.rx_active      = next_s.ctrl.rx_en;
        next_s.rx_serial_data = next_s.ctrl.rx_en ? rxd_pin_in
                                                  : spce_pkg::RX_IDLE_LVL;
        next_s.rxd_gpio_data  = rxd_pin_in;
        next_s.tx_active      = next_s.ctrl.tx_en;
        next_s.txd_pin_out    = next_s.ctrl.tx_en ? tx_serial_out : gpio_txd_data;
        next_s.txd_pin_oe_n   = next_s.ctrl.tx_en ? 1'b0 : gpio_txd_oe_n;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '{ctrl: spce_pkg::CTRL_RESET, flags: spce_pkg::FLAGS_RESET,
                   mask: spce_pkg::MASK_RESET, prdata: '0,
                   rx_serial_data: spce_pkg::RX_IDLE_LVL, rxd_gpio_data: 1'b1,
                   txd_pin_oe_n: 1'b1, default: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata         = s.prdata;
    assign pready         = s.pready;
    assign pslverr        = s.pslverr;
    assign rx_active      = s.rx_active;
    assign tx_active      = s.tx_active;
    assign rx_serial_data = s.rx_serial_data;
    assign rxd_gpio_data  = s.rxd_gpio_data;
    assign txd_pin_out    = s.txd_pin_out;
    assign txd_pin_oe_n   = s.txd_pin_oe_n;
    assign rx_full_irq    = s.rx_full_irq;
    assign rx_error_irq   = s.rx_error_irq;
    assign tx_empty_irq   = s.tx_empty_irq;
    assign tx_end_irq     = s.tx_end_irq;
    assign irq            = s.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_plain_frame;
        rx_event.valid && s.ctrl.rx_en && !s.ctrl.mp_filter_en;
    endsequence

    sequence s_filtered_miss;
        rx_event.valid && s.ctrl.rx_en && s.ctrl.mp_filter_en && !rx_event.mp_bit
        && !s.flags[spce_pkg::ST_RX_FULL];
    endsequence

    sequence s_release_frame;
        rx_event.valid && s.ctrl.rx_en && s.ctrl.mp_filter_en && rx_event.mp_bit;
    endsequence

    property p_apb_answer;
        s_setup |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("APB access phase not answered in one cycle");

    property p_tx_end_gate;
        tx_end_irq == (s.ctrl.tx_end_ie && $past(tx_all_sent));
    endproperty
    a_tx_end_gate: assert property (p_tx_end_gate)
        else $error("Transmit-end request does not follow its enable");

    property p_plain_receive;
        s_plain_frame |=> s.flags[spce_pkg::ST_RX_FULL];
    endproperty
    a_plain_receive: assert property (p_plain_receive)
        else $error("Unfiltered frame did not set the receive-full flag");

    property p_mp_release;
        s_release_frame |=> !s.ctrl.mp_filter_en && s.flags[spce_pkg::ST_RX_FULL];
    endproperty
    a_mp_release: assert property (p_mp_release)
        else $error("Multiprocessor frame did not clear the filter enable");

    property p_mp_block_flag;
        s_filtered_miss |=> !s.flags[spce_pkg::ST_RX_FULL] && s.ctrl.mp_filter_en;
    endproperty
    a_mp_block_flag: assert property (p_mp_block_flag)
        else $error("Filtered frame set the receive-full flag");

    property p_mp_block_irq;
        s.ctrl.mp_filter_en |-> !rx_full_irq && !rx_error_irq;
    endproperty
    a_mp_block_irq: assert property (p_mp_block_irq)
        else $error("Receive request raised while filter enabled");

    property p_rx_off;
        !s.ctrl.rx_en |-> !rx_active && rx_serial_data == spce_pkg::RX_IDLE_LVL
                          && rxd_gpio_data == $past(rxd_pin_in);
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("Receiver active or pin not GPIO while disabled");

    property p_rx_on;
        s.ctrl.rx_en |-> rx_active && rx_serial_data == $past(rxd_pin_in);
    endproperty
    a_rx_on: assert property (p_rx_on)
        else $error("Receive pin not routed to receiver while enabled");

    property p_tx_on;
        s.ctrl.tx_en |-> tx_active && !txd_pin_oe_n && txd_pin_out == $past(tx_serial_out);
    endproperty
    a_tx_on: assert property (p_tx_on)
        else $error("Transmit pin not driven with serial data while enabled");

    property p_rx_ie_gate;
        !s.ctrl.rx_ie |-> !rx_full_irq && !rx_error_irq;
    endproperty
    a_rx_ie_gate: assert property (p_rx_ie_gate)
        else $error("Receive request raised while its enable is low");

    property p_tx_empty_off;
        !s.ctrl.tx_empty_ie |-> !tx_empty_irq;
    endproperty
    a_tx_empty_off: assert property (p_tx_empty_off)
        else $error("Transmit-empty request raised while disabled");

    property p_tx_empty_on;
        (s.ctrl.tx_empty_ie && tx_data_empty) ##1 s.ctrl.tx_empty_ie |-> tx_empty_irq;
    endproperty
    a_tx_empty_on: assert property (p_tx_empty_on)
        else $error("Transmit-empty request missing while register empty");

    property p_irq_line;
        ##1 (irq == |({tx_end_irq, tx_empty_irq,
                       rx_error_irq && s.flags[spce_pkg::ST_OVERRUN],
                       rx_error_irq && s.flags[spce_pkg::ST_FRAMING],
                       rx_full_irq} & s.mask));
    endproperty
    a_irq_line: assert property (p_irq_line)
        else $error("Interrupt line disagrees with masked requests");

    sequence s_unmapped_setup;
        psel && !penable && paddr != spce_pkg::CTRL_OFFSET
        && paddr != spce_pkg::STATUS_OFFSET
        && paddr != spce_pkg::MASK_OFFSET;
    endsequence

    // Unmapped access answers with an error and reads as zero
    property p_bus_error;
        s_unmapped_setup |=> pready && pslverr && prdata == '0;
    endproperty
    a_bus_error: assert property (p_bus_error)
        else $error("Unmapped access not answered with an error");

    // A frame with the receiver off, and no status write in flight
    sequence s_idle_frame;
        rx_event.valid && !s.ctrl.rx_en && !(wr_access && paddr == spce_pkg::STATUS_OFFSET);
    endsequence

    property p_rx_off_discard;
        s_idle_frame |=> $stable(s.flags);
    endproperty
    a_rx_off_discard: assert property (p_rx_off_discard)
        else $error("Frame changed the flags while the receiver is off");

    // Reset values of the pin outputs differ from the port inputs, so skip that edge
    property p_tx_off;
        !s.ctrl.tx_en && $past(presetn) |-> !tx_active
                                            && txd_pin_oe_n == $past(gpio_txd_oe_n)
                                            && txd_pin_out == $past(gpio_txd_data);
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("Transmit pin not handed to the port while disabled");

    property p_tx_end_off;
        !s.ctrl.tx_end_ie |-> !tx_end_irq;
    endproperty
    a_tx_end_off: assert property (p_tx_end_off)
        else $error("Transmit-end request raised while disabled");

endmodule : spce_top

// ==== spce_pkg.sv ====
// Package with register map, field layout and carrier types of the serial control-enable block
// Function
// - Transmit-end enable gates the transmit-end request
// - Filter off means plain reception, no filtering
// - Multiprocessor bit 1 frame clears filter enable
// - Filter on blocks receive requests and flags
// - Receive disabled: receiver idle, pin is GPIO
// - Receive enabled: receiver runs, pin is data
// - Transmit enabled: transmitter runs, pin drives data
// - Receive enable gates full and error requests
// - Transmit-empty enable 0 blocks empty request
package spce_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] MASK_OFFSET   = 8'h08;

    // Control register bit positions
    localparam int CTRL_TX_EN       = 0;
    localparam int CTRL_RX_EN       = 1;
    localparam int CTRL_MP_FILTER   = 2;
    localparam int CTRL_TX_END_IE   = 3;
    localparam int CTRL_RX_IE       = 4;
    localparam int CTRL_TX_EMPTY_IE = 5;
    localparam int CTRL_W           = 6;

    // Status and mask register bit positions
    localparam int ST_RX_FULL  = 0;
    localparam int ST_FRAMING  = 1;
    localparam int ST_OVERRUN  = 2;
    localparam int ST_TX_EMPTY = 3;
    localparam int ST_TX_END   = 4;
    localparam int ST_W        = 5;

    localparam logic [CTRL_W-1:0] CTRL_RESET   = 6'h00;
    localparam logic [ST_W-1:0]   MASK_RESET   = 5'h00;
    localparam logic [2:0]        FLAGS_RESET  = 3'h0;
    localparam logic              RX_IDLE_LVL  = 1'b1;

    typedef struct packed {
        logic tx_empty_ie;
        logic rx_ie;
        logic tx_end_ie;
        logic mp_filter_en;
        logic rx_en;
        logic tx_en;
    } spce_ctrl_type;

    // One received frame from the receive shifter, valid for one cycle
    typedef struct packed {
        logic valid;
        logic mp_bit;
        logic framing_err;
        logic overrun;
    } spce_rx_event_type;

    typedef struct packed {
        spce_ctrl_type       ctrl;
        logic [2:0]          flags;
        logic [ST_W-1:0]     mask;
        logic                tx_empty_seen;
        logic                tx_end_seen;
        logic [DATA_W-1:0]   prdata;
        logic                pready;
        logic                pslverr;
        logic                rx_full_irq;
        logic                rx_error_irq;
        logic                tx_empty_irq;
        logic                tx_end_irq;
        logic                irq;
        logic                rx_active;
        logic                tx_active;
        logic                rx_serial_data;
        logic                rxd_gpio_data;
        logic                txd_pin_out;
        logic                txd_pin_oe_n;
    } spce_state_type;

endpackage : spce_pkg

// ==== spce_remote.sv ====
// Remote serial station model: frame events, pin levels and transmitter status
`timescale 1ns/1ns
module spce_remote
(
    input  wire logic                   pclk,
    output spce_pkg::spce_rx_event_type rx_event,
    output logic                        rxd_pin_in,
    output logic                        tx_serial_out,
    output logic                        tx_data_empty,
    output logic                        tx_all_sent
);
    initial
    begin
        rx_event      = '0;
        rxd_pin_in    = 1'b1;
        tx_serial_out = 1'b1;
        tx_data_empty = 1'b0;
        tx_all_sent   = 1'b0;
    end

    // One frame pulse; the fields are scrambled once valid drops
    task automatic send(input logic mp, input logic fe, input logic ov);
        @(posedge pclk);
        rx_event <= {1'b1, mp, fe, ov};
        @(posedge pclk);
        rx_event <= {1'b0, ~mp, ~fe, ~ov};
    endtask : send

    task automatic lines(input logic rxd, input logic txs, input logic emp, input logic fin);
        @(posedge pclk);
        rxd_pin_in    <= rxd;
        tx_serial_out <= txs;
        tx_data_empty <= emp;
        tx_all_sent   <= fin;
    endtask : lines
endmodule : spce_remote

// ==== tb.sv ====
// Testbench for the serial control-enable block
`timescale 1ns/1ns
module tb;
    localparam logic [31:0] c_tx  = 32'h1 << spce_pkg::CTRL_TX_EN;
    localparam logic [31:0] c_rx  = 32'h1 << spce_pkg::CTRL_RX_EN;
    localparam logic [31:0] c_mp  = 32'h1 << spce_pkg::CTRL_MP_FILTER;
    localparam logic [31:0] c_te  = 32'h1 << spce_pkg::CTRL_TX_END_IE;
    localparam logic [31:0] c_ri  = 32'h1 << spce_pkg::CTRL_RX_IE;
    localparam logic [31:0] c_xe  = 32'h1 << spce_pkg::CTRL_TX_EMPTY_IE;
    localparam logic [31:0] s_ful = 32'h1 << spce_pkg::ST_RX_FULL;
    localparam logic [31:0] s_fer = 32'h1 << spce_pkg::ST_FRAMING;
    localparam logic [31:0] s_ovr = 32'h1 << spce_pkg::ST_OVERRUN;
    localparam logic [31:0] s_emp = 32'h1 << spce_pkg::ST_TX_EMPTY;
    localparam logic [31:0] s_end = 32'h1 << spce_pkg::ST_TX_END;

    logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [spce_pkg::ADDR_W-1:0] paddr;
    logic [31:0]                 pwdata, prdata, rd;
    spce_pkg::spce_rx_event_type rx_event;
    logic                        rxd_pin_in, tx_serial_out, tx_data_empty, tx_all_sent;
    logic                        gpio_txd_data, gpio_txd_oe_n, rx_active, tx_active;
    logic                        rx_serial_data, rxd_gpio_data, txd_pin_out, txd_pin_oe_n;
    logic                        rx_full_irq, rx_error_irq, tx_empty_irq, tx_end_irq, irq;
    int                          fails, samples_checked;

    spce_top u_spce_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .rx_event, .tx_data_empty, .tx_all_sent,
        .tx_serial_out, .gpio_txd_data, .gpio_txd_oe_n, .rxd_pin_in, .rx_active,
        .tx_active, .rx_serial_data, .rxd_gpio_data, .txd_pin_out, .txd_pin_oe_n,
        .rx_full_irq, .rx_error_irq, .tx_empty_irq, .tx_end_irq, .irq);

    spce_remote u_spce_remote (.pclk, .rx_event, .rxd_pin_in, .tx_serial_out,
        .tx_data_empty, .tx_all_sent);

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic bit_is(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask : bit_is

    // One APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (pready !== 1'b1)
        begin
            fails++;
            wrap_up();
        end
        else
        begin
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask : tick

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        gpio_txd_data = 1'b1;
        gpio_txd_oe_n = 1'b1;
        fails = 0;
        samples_checked = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, spce_pkg::CTRL_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, spce_pkg::MASK_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 8'h0c, 32'hffffffff);
        apb(1'b0, 8'h0c, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("test reset done");

        // Transmit pin: port data while off, transmitter data while on
        u_spce_remote.lines(1'b0, 1'b0, 1'b0, 1'b0);
        gpio_txd_oe_n <= 1'b0;
        tick(3);
        check({txd_pin_oe_n, txd_pin_out}, 32'h1);
        gpio_txd_oe_n <= 1'b1;
        apb(1'b1, spce_pkg::CTRL_OFFSET, c_tx);
        tick(3);
        check({tx_active, txd_pin_oe_n, txd_pin_out}, 32'h4);
        u_spce_remote.lines(1'b0, 1'b1, 1'b0, 1'b0);
        tick(3);
        bit_is(txd_pin_out, 1'b1);
        $display("test transmit pin done");

        // Receive pin: idle high while off, pin level while on
        check({rx_active, rx_serial_data, rxd_gpio_data}, 32'h2);
        apb(1'b1, spce_pkg::CTRL_OFFSET, c_rx);
        tick(3);
        check({rx_active, rx_serial_data}, 32'h2);
        $display("test receive pin done");

        // Plain reception and the receive enable gate
        apb(1'b1, spce_pkg::MASK_OFFSET, s_ful | s_fer);
        apb(1'b1, spce_pkg::CTRL_OFFSET, c_rx | c_ri);
        u_spce_remote.send(1'b0, 1'b1, 1'b1);
        tick(3);
        check({rx_full_irq, rx_error_irq, irq}, 32'h7);
        apb(1'b0, spce_pkg::STATUS_OFFSET, 32'h0);
        check(rd, s_ful | s_fer | s_ovr);
        apb(1'b1, spce_pkg::CTRL_OFFSET, c_rx);
        tick(3);
        check({rx_full_irq, rx_error_irq}, 32'h0);
        apb(1'b1, spce_pkg::STATUS_OFFSET, 32'h7);
        tick(3);
        bit_is(irq, 1'b0);
        $display("test plain reception done");

        // Filter holds off until a multiprocessor frame, then clears itself
        apb(1'b1, spce_pkg::CTRL_OFFSET, c_rx | c_ri | c_mp);
        u_spce_remote.send(1'b0, 1'b1, 1'b1);
        tick(3);
        check({rx_full_irq, rx_error_irq, irq}, 32'h0);
        apb(1'b0, spce_pkg::STATUS_OFFSET, 32'h0);
        check(rd, 32'h0);
        u_spce_remote.send(1'b1, 1'b0, 1'b0);
        tick(3);
        check({rx_full_irq, rx_error_irq, irq}, 32'h5);
        apb(1'b0, spce_pkg::CTRL_OFFSET, 32'h0);
        check(rd, c_rx | c_ri);
        apb(1'b0, spce_pkg::STATUS_OFFSET, 32'h0);
        check(rd, s_ful);
        apb(1'b1, spce_pkg::STATUS_OFFSET, 32'h7);
        apb(1'b1, spce_pkg::CTRL_OFFSET, c_ri);
        u_spce_remote.send(1'b0, 1'b0, 1'b1);
        apb(1'b0, spce_pkg::STATUS_OFFSET, 32'h0);
        check(rd, 32'h0);
        $display("test filter done");

        // Transmit requests follow their enables and the mask
        u_spce_remote.lines(1'b1, 1'b1, 1'b1, 1'b1);
        tick(3);
        check({tx_empty_irq, tx_end_irq, irq}, 32'h0);
        apb(1'b0, spce_pkg::STATUS_OFFSET, 32'h0);
        check(rd, s_emp | s_end);
        apb(1'b1, spce_pkg::CTRL_OFFSET, c_te | c_xe);
        tick(3);
        check({tx_empty_irq, tx_end_irq, irq}, 32'h6);
        apb(1'b1, spce_pkg::MASK_OFFSET, s_emp | s_end);
        tick(3);
        bit_is(irq, 1'b1);
        apb(1'b1, spce_pkg::CTRL_OFFSET, c_xe);
        tick(3);
        check({tx_empty_irq, tx_end_irq}, 32'h2);
        u_spce_remote.lines(1'b1, 1'b1, 1'b0, 1'b1);
        tick(3);
        check({tx_empty_irq, irq}, 32'h0);
        $display("test transmit requests done");
        wrap_up();
    end

    initial
    begin
        #2000000;
        fails++;
        wrap_up();
    end
endmodule : tb
